// ### rtl/sds_spi_core.sv
// Module: SPI data port, FIFO flags, bit-rate prescaler and interrupt mask behind AXI4-Lite
// Contract
// RL1: Reading the data port returns and removes the oldest receive FIFO entry.
// RL2: Writing the data port pushes the word into the transmit FIFO.
// RL3: Short frames take transmit data from low bits; upper bits ignored.
// RL4: Short received frames are right-aligned, upper bits zero.
// RL5: Status bit 0 is one while transmit FIFO is empty; resets one.
// RL6: Status bit 1 is zero when transmit FIFO full; resets one.
// RL7: Status bit 2 is one while receive FIFO holds data; resets zero.
// RL8: Status bit 3 is one when receive FIFO full; resets zero.
// RL9: Status bit 4 is one while shifting or transmit FIFO not empty.
// RL10: Software programs the prescaler only with even values 2 to 254.
// RL11: Bit rate is kernel clock over prescaler times one plus rate setting.
// RL12: Mask bit 0 enables the receive overflow interrupt; resets zero.
// RL13: Mask bit 1 enables the receive timeout interrupt; resets zero.
// RL14: Mask bit 2 enables the receive level interrupt; resets zero.
// RL15: Mask bit 3 enables the transmit level interrupt; resets zero.
// RL16: Mask bit 4 enables the transmit underrun interrupt; resets zero.
// RL17: Mask bit 5 enables the transmit empty interrupt; resets zero.
// RL18: Receive level condition at 1, 4 or 8 entries for codes 0, 1, 2.
// RL19: Transmit level condition at 1, 4 or 8 entries for codes 0, 1, 2.
// RL20: Interrupt output is OR of sources whose raw and mask are both one.
`timescale 1ns/10ps
module sds_spi_core
  import sds_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int RX_TIMEOUT_CYCLES = 64
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic spi_sclk_o,
  output logic spi_mosi_o,
  output logic spi_cs_n_o,
  input wire logic spi_miso_i,
  output logic irq_o
);
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(FIFO_DEPTH - 1);
  localparam logic [15:0] TIMEOUT_C = 16'(RX_TIMEOUT_CYCLES);
  // ****************
  // Declarations
  // ****************
  logic aw_hold_reg, w_hold_reg, awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic ovf_reg, stale_reg, irq_reg, sclk_reg, mosi_reg, cs_n_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [3:0] w_strb_reg;
  logic [4:0] bit_cnt_reg;
  logic [5:0] mask_reg;
  logic [7:0] aw_addr_reg, prescaler_reg;
  logic [15:0] stale_cnt_reg, div_cnt_reg;
  logic [31:0] w_data_reg, rdata_reg, frame_cfg_reg, link_cfg_reg, tx_shift_reg, rx_shift_reg;
  logic [31:0] tx_mem [FIFO_DEPTH];
  logic [31:0] rx_mem [FIFO_DEPTH];
  logic [PW-1:0] tx_wr_reg, tx_rd_reg, rx_wr_reg, rx_rd_reg;
  logic [CW-1:0] tx_cnt_reg, rx_cnt_reg;
  sds_state_e state_reg;
  logic wr_fire, rd_take, wr_is_data, tx_push, tx_pop, rx_push, rx_pop, tx_full, rx_full;
  logic div_end, frame_done, rd_ok;
  logic [4:0] frame_last;
  logic [5:0] raw_ev;
  logic [7:0] scr_val;
  logic [15:0] half_period;
  logic [CW-1:0] rx_thr, tx_thr;
  logic [31:0] flags, rd_mux;

  // ****************
  // Handshake and shared terms
  // ****************
  // Only one write and one read under way; the response frees the channel
  assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign rd_take = s_axi_arvalid_i & arready_reg;
  assign wr_is_data = (aw_addr_reg == OFS_FIFO_DATA_PORT) & (|w_strb_reg);
  assign tx_full = (tx_cnt_reg == DEPTH_C);
  assign rx_full = (rx_cnt_reg == DEPTH_C);
  assign tx_push = wr_fire & wr_is_data & ~tx_full; // RL2
  assign rx_pop = rd_take & (s_axi_araddr_i == OFS_FIFO_DATA_PORT) & (rx_cnt_reg != '0); // RL1
  assign frame_last = frame_cfg_reg[FRAME_SIZE_LSB +: 5];
  assign scr_val = frame_cfg_reg[SCR_LSB +: 8];
  // Prescaler is even, so half a bit is (prescaler/2) x (1 + rate setting)
  assign half_period = 16'(prescaler_reg[7:1]) * (16'(scr_val) + 16'h0001); // RL11
  assign div_end = (div_cnt_reg + 16'h0001 >= half_period);
  assign tx_pop = (state_reg == ST_IDLE) & link_cfg_reg[LINK_ENABLE_BIT] &
                  (tx_cnt_reg != '0) & (half_period != 16'h0000);
  assign frame_done = (state_reg == ST_HIGH) & div_end & (bit_cnt_reg == frame_last);
  assign rx_push = frame_done & ~rx_full;

  // Level thresholds; reserved codes never trigger
  always_comb begin
    case (link_cfg_reg[RX_SEL_LSB +: 3]) // RL18
      LVL_SEL_1: rx_thr = CW'(LVL_CNT_1);
      LVL_SEL_4: rx_thr = CW'(LVL_CNT_4);
      LVL_SEL_8: rx_thr = CW'(LVL_CNT_8);
      default: rx_thr = '1;
    endcase
    case (link_cfg_reg[TX_SEL_LSB +: 3]) // RL19
      LVL_SEL_1: tx_thr = CW'(LVL_CNT_1);
      LVL_SEL_4: tx_thr = CW'(LVL_CNT_4);
      LVL_SEL_8: tx_thr = CW'(LVL_CNT_8);
      default: tx_thr = '1;
    endcase
  end
  // Raw event vector; underrun cannot occur while this end drives the clock
  always_comb begin
    raw_ev = '0;
    raw_ev[EV_RX_OVERFLOW] = ovf_reg;
    raw_ev[EV_RX_STALE] = stale_reg;
    raw_ev[EV_RX_LEVEL] = (link_cfg_reg[RX_SEL_LSB +: 3] <= LVL_SEL_8) & (rx_cnt_reg >= rx_thr);
    raw_ev[EV_TX_LEVEL] = (link_cfg_reg[TX_SEL_LSB +: 3] <= LVL_SEL_8) & (tx_cnt_reg >= tx_thr);
    raw_ev[EV_TX_STARVED] = 1'b0;
    raw_ev[EV_TX_DRAINED] = (tx_cnt_reg == '0);
  end
  // Status flags straight from FIFO counts and the shifter
  always_comb begin
    flags = '0;
    flags[FLAG_TX_EMPTY] = (tx_cnt_reg == '0); // RL5
    flags[FLAG_TX_SPACE] = ~tx_full; // RL6
    flags[FLAG_RX_DATA] = (rx_cnt_reg != '0); // RL7
    flags[FLAG_RX_FULL] = rx_full; // RL8
    flags[FLAG_BUSY] = (state_reg != ST_IDLE) | (tx_cnt_reg != '0); // RL9
  end
  // Read decode; an empty receive FIFO reads zero
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr_i)
      OFS_FRAME_CFG: rd_mux = frame_cfg_reg;
      OFS_LINK_CFG: rd_mux = link_cfg_reg;
      OFS_FIFO_DATA_PORT: rd_mux = (rx_cnt_reg != '0) ? rx_mem[rx_rd_reg] : 32'h0000_0000; // RL1
      OFS_FIFO_AND_BUSY_FLAGS: rd_mux = flags;
      OFS_BIT_RATE_PRESCALER: rd_mux = {24'h00_0000, prescaler_reg};
      OFS_INTERRUPT_ENABLE_MASK: rd_mux = {26'h000_0000, mask_reg};
      OFS_RAW_EVENTS: rd_mux = {26'h000_0000, raw_ev};
      OFS_MASKED_EVENTS: rd_mux = {26'h000_0000, raw_ev & mask_reg};
      OFS_EVENT_CLEAR: rd_mux = 32'h0000_0000;
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // ****************
  // AXI4-Lite write channel
  // ****************
  // Address and data are caught in either order; ready drops until the response
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i & awready_reg) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid_i & wready_reg) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
        wready_reg <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (aw_addr_reg > OFS_EVENT_CLEAR || aw_addr_reg == OFS_FIFO_AND_BUSY_FLAGS ||
                      aw_addr_reg[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid_reg & s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end
  // Writable registers; byte enables honoured per lane
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      frame_cfg_reg <= FRAME_CFG_RESET;
      link_cfg_reg <= LINK_CFG_RESET;
      prescaler_reg <= PRESCALER_RESET;
      mask_reg <= MASK_RESET; // RL12 RL13 RL14 RL15 RL16 RL17
    end else if (wr_fire) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_reg[b]) begin
          if (aw_addr_reg == OFS_FRAME_CFG) frame_cfg_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
          if (aw_addr_reg == OFS_LINK_CFG) link_cfg_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
        end
      end
      // Only even 2..254 is meaningful; other values are stored as written
      if (aw_addr_reg == OFS_BIT_RATE_PRESCALER && w_strb_reg[0]) begin
        prescaler_reg <= w_data_reg[7:0]; // RL10
      end
      if (aw_addr_reg == OFS_INTERRUPT_ENABLE_MASK && w_strb_reg[0]) begin
        mask_reg <= w_data_reg[5:0];
      end
    end
  end
  // ****************
  // AXI4-Lite read channel
  // ****************
  // Data is captured at the address edge, so the FIFO pop and read agree
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else begin
      if (rd_take) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg & s_axi_rready_i) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end
  // ****************
  // FIFOs
  // ****************
  // Transmit FIFO; a push while full is dropped
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tx_wr_reg <= '0;
      tx_rd_reg <= '0;
      tx_cnt_reg <= '0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wr_reg] <= w_data_reg; // RL2
        tx_wr_reg <= (tx_wr_reg == LAST_PTR) ? '0 : tx_wr_reg + PW'(1);
      end
      if (tx_pop) begin
        tx_rd_reg <= (tx_rd_reg == LAST_PTR) ? '0 : tx_rd_reg + PW'(1);
      end
      tx_cnt_reg <= tx_cnt_reg + CW'(tx_push) - CW'(tx_pop);
    end
  end
  // Receive FIFO; a frame arriving while full is lost and flagged
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rx_wr_reg <= '0;
      rx_rd_reg <= '0;
      rx_cnt_reg <= '0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wr_reg] <= rx_shift_reg; // RL4
        rx_wr_reg <= (rx_wr_reg == LAST_PTR) ? '0 : rx_wr_reg + PW'(1);
      end
      if (rx_pop) begin
        rx_rd_reg <= (rx_rd_reg == LAST_PTR) ? '0 : rx_rd_reg + PW'(1); // RL1
      end
      rx_cnt_reg <= rx_cnt_reg + CW'(rx_push) - CW'(rx_pop);
    end
  end
  // ****************
  // Sticky events and interrupt output
  // ****************
  // A new event in the clearing cycle wins over the clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ovf_reg <= 1'b0;
      stale_reg <= 1'b0;
      stale_cnt_reg <= 16'h0000;
    end else begin
      if (frame_done & rx_full) begin
        ovf_reg <= 1'b1;
      end else if (wr_fire && aw_addr_reg == OFS_EVENT_CLEAR && w_data_reg[CLR_RX_OVERFLOW]) begin
        ovf_reg <= 1'b0;
      end
      // Stale timer restarts on every data port read and while the FIFO is empty
      if (rx_pop || rx_cnt_reg == '0) begin
        stale_cnt_reg <= 16'h0000;
      end else if (stale_cnt_reg != TIMEOUT_C) begin
        stale_cnt_reg <= stale_cnt_reg + 16'h0001;
      end
      if (stale_cnt_reg + 16'h0001 == TIMEOUT_C && !rx_pop && rx_cnt_reg != '0) begin
        stale_reg <= 1'b1;
      end else if (wr_fire && aw_addr_reg == OFS_EVENT_CLEAR && w_data_reg[CLR_RX_STALE]) begin
        stale_reg <= 1'b0;
      end
    end
  end
  // Registered so the pin is glitch free
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(raw_ev & mask_reg); // RL20 RL12 RL13 RL14 RL15 RL16 RL17
    end
  end
  // ****************
  // Serial shifter, clock idle low, sample on rising edge
  // ****************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      div_cnt_reg <= 16'h0000;
      bit_cnt_reg <= 5'h00;
      tx_shift_reg <= 32'h0000_0000;
      rx_shift_reg <= 32'h0000_0000;
      sclk_reg <= 1'b0;
      mosi_reg <= 1'b0;
      cs_n_reg <= 1'b1;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (tx_pop) begin
            // Frame's top bit moved to bit 31; bits above the frame fall away
            tx_shift_reg <= tx_mem[tx_rd_reg] << (5'd31 - frame_last); // RL3
            mosi_reg <= tx_mem[tx_rd_reg][frame_last];
            rx_shift_reg <= 32'h0000_0000; // RL4
            bit_cnt_reg <= 5'h00;
            div_cnt_reg <= 16'h0000;
            cs_n_reg <= 1'b0;
            state_reg <= ST_LOW;
          end
        end
        ST_LOW: begin
          div_cnt_reg <= div_end ? 16'h0000 : div_cnt_reg + 16'h0001; // RL11
          if (div_end) begin
            sclk_reg <= 1'b1;
            rx_shift_reg <= {rx_shift_reg[30:0], spi_miso_i};
            state_reg <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          div_cnt_reg <= div_end ? 16'h0000 : div_cnt_reg + 16'h0001; // RL11
          if (div_end) begin
            sclk_reg <= 1'b0;
            if (bit_cnt_reg == frame_last) begin
              cs_n_reg <= 1'b1;
              mosi_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end else begin
              tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
              mosi_reg <= tx_shift_reg[30];
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
              state_reg <= ST_LOW;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          sclk_reg <= 1'b0;
          cs_n_reg <= 1'b1;
        end
      endcase
    end
  end
  // ****************
  // Outputs, all from flip-flops
  // ****************
  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign spi_sclk_o = sclk_reg;
  assign spi_mosi_o = mosi_reg;
  assign spi_cs_n_o = cs_n_reg;
  assign irq_o = irq_reg;

endmodule : sds_spi_core

// ### include/sds_pkg.sv
// Package: register map, field layout, reset values and states of the SPI data/status block
package sds_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_FRAME_CFG = 8'h00;
  localparam logic [7:0] OFS_LINK_CFG = 8'h04;
  localparam logic [7:0] OFS_FIFO_DATA_PORT = 8'h08;
  localparam logic [7:0] OFS_FIFO_AND_BUSY_FLAGS = 8'h0c;
  localparam logic [7:0] OFS_BIT_RATE_PRESCALER = 8'h10;
  localparam logic [7:0] OFS_INTERRUPT_ENABLE_MASK = 8'h14;
  localparam logic [7:0] OFS_RAW_EVENTS = 8'h18;
  localparam logic [7:0] OFS_MASKED_EVENTS = 8'h1c;
  localparam logic [7:0] OFS_EVENT_CLEAR = 8'h20;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int FRAME_SIZE_LSB = 0;   // Frame bits minus one, 5 bits
  localparam int SCR_LSB = 8;          // Serial clock rate setting, 8 bits
  localparam int LINK_ENABLE_BIT = 0;
  localparam int RX_SEL_LSB = 7;       // Three bits
  localparam int TX_SEL_LSB = 10;      // Three bits
  localparam int FLAG_TX_EMPTY = 0;
  localparam int FLAG_TX_SPACE = 1;
  localparam int FLAG_RX_DATA = 2;
  localparam int FLAG_RX_FULL = 3;
  localparam int FLAG_BUSY = 4;
  localparam int EV_RX_OVERFLOW = 0;
  localparam int EV_RX_STALE = 1;
  localparam int EV_RX_LEVEL = 2;
  localparam int EV_TX_LEVEL = 3;
  localparam int EV_TX_STARVED = 4;
  localparam int EV_TX_DRAINED = 5;
  localparam int EV_COUNT = 6;
  localparam int CLR_RX_OVERFLOW = 0;
  localparam int CLR_RX_STALE = 1;
  localparam int CLR_TX_STARVED = 2;

  // ****************************************************************
  // Reset values and level codes
  // ****************************************************************
  localparam logic [31:0] FRAME_CFG_RESET = 32'h0000_0007;  // 8-bit frames, rate setting 0
  localparam logic [31:0] LINK_CFG_RESET = 32'h0000_0000;
  localparam logic [7:0] PRESCALER_RESET = 8'h00;
  localparam logic [5:0] MASK_RESET = 6'h00;
  localparam logic [2:0] LVL_SEL_1 = 3'h0;
  localparam logic [2:0] LVL_SEL_4 = 3'h1;
  localparam logic [2:0] LVL_SEL_8 = 3'h2;
  localparam int LVL_CNT_1 = 1;
  localparam int LVL_CNT_4 = 4;
  localparam int LVL_CNT_8 = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Shifter states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW = 3'b010,
    ST_HIGH = 3'b100
  } sds_state_e;

endpackage : sds_pkg

// ### verification/sds_spi_core_properties.sv
// Checker: bus answer, status flag and link properties of the SPI data/status block
`timescale 1ns/10ps
module sds_spi_core_properties
  import sds_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic spi_sclk_o,
  input wire logic spi_cs_n_o,
  input wire logic irq_o
);
  // ********
  // Properties
  // ********
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic mask_seen_reg;
  // Irq may only appear once software has touched the mask
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mask_seen_reg <= 1'b0;
    end else if (s_axi_awvalid_i && s_axi_awready_o &&
                 s_axi_awaddr_i == OFS_INTERRUPT_ENABLE_MASK) begin
      mask_seen_reg <= 1'b1;
    end
  end
  sequence s_rd_at(logic [7:0] a);
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == a;
  endsequence
  sequence s_flags;
    s_rd_at(OFS_FIFO_AND_BUSY_FLAGS);
  endsequence
  a_data_read_ok: assert property (
    s_rd_at(OFS_FIFO_DATA_PORT) |=> s_axi_rvalid_o && s_axi_rresp_o == RESP_OKAY)
    else $error("data port read not answered okay");
  a_flags_clean: assert property (
    s_flags |=> s_axi_rdata_o[31:5] == 27'h0 && s_axi_rresp_o == RESP_OKAY)
    else $error("status read has stray bits");
  a_tx_empty_space: assert property (
    s_flags |=> !s_axi_rdata_o[FLAG_TX_EMPTY] || s_axi_rdata_o[FLAG_TX_SPACE])
    else $error("empty transmit fifo shown full");
  a_rx_full_data: assert property (
    s_flags |=> !s_axi_rdata_o[FLAG_RX_FULL] || s_axi_rdata_o[FLAG_RX_DATA])
    else $error("full receive fifo shown empty");
  a_busy_pending: assert property (
    s_flags |=> s_axi_rdata_o[FLAG_TX_EMPTY] || s_axi_rdata_o[FLAG_BUSY])
    else $error("pending transmit data not busy");
  a_busy_in_frame: assert property (
    !spi_cs_n_o ##1 (!spi_cs_n_o && s_axi_arvalid_i && s_axi_arready_o &&
    s_axi_araddr_i == OFS_FIFO_AND_BUSY_FLAGS) |=> s_axi_rdata_o[FLAG_BUSY])
    else $error("busy low during a frame");
  a_irq_masked: assert property (!mask_seen_reg |-> !irq_o)
    else $error("irq with reset mask");
  a_sclk_framed: assert property (spi_sclk_o |-> !spi_cs_n_o)
    else $error("serial clock outside a frame");
endmodule : sds_spi_core_properties

bind sds_spi_core sds_spi_core_properties i_sds_spi_core_properties (.core_clk_i, .rst_i,
  .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_araddr_i, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .spi_sclk_o,
  .spi_cs_n_o, .irq_o);

// ### verification/sds_spi_peer.sv
// Peer model: SPI slave in mode 0, answering each frame from a reply table
`timescale 1ns/10ps
module sds_spi_peer #(
  parameter int FB = 8
) (
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic cs_n_i,
  output logic miso_o
);
  // ********
  // Slave behaviour
  // ********
  logic [FB-1:0] rep [0:15];
  logic [FB-1:0] got [0:15];
  logic [FB-1:0] sh;
  logic [FB-1:0] cap;
  logic act = 1'b0;
  int nf = 0;
  initial miso_o = 1'b0;
  // Reply MSB must be ready before the first rising sclk
  always @(negedge cs_n_i) begin
    act = 1'b1;
    sh = rep[nf];
    miso_o = sh[FB-1];
  end
  // Shift out on falling sclk, capture on rising
  always @(negedge sclk_i) begin
    if (act) begin
      sh = sh << 1;
      miso_o = sh[FB-1];
    end
  end
  always @(posedge sclk_i) cap = {cap[FB-2:0], mosi_i};
  // Released line flips so a held value cannot pass for data
  always @(posedge cs_n_i) begin
    if (act) begin
      got[nf] = cap;
      nf++;
      act = 1'b0;
      miso_o = ~miso_o;
    end
  end
endmodule : sds_spi_peer

// ### verification/tb.sv
// Testbench: register bus, SPI link and interrupt checks of the SPI data/status block
`timescale 1ns/10ps
module tb;
  import sds_pkg::*;
  // ********
  // Signals and instances
  // ********
  localparam int PS = 4;
  localparam int SERIAL_CLOCK_RATE_SETTING = 1;
  localparam int FB = 8;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] s_axi_awaddr_i = 8'h00;
  logic s_axi_awvalid_i = 1'b0;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0;
  logic [7:0] s_axi_araddr_i = 8'h00;
  logic s_axi_arvalid_i = 1'b0;
  logic s_axi_rready_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic spi_sclk_o, spi_mosi_o, spi_cs_n_o, spi_miso_i, irq_o;
  int n_errors = 0;
  int tests_run = 0;
  int lv [0:2] = '{LVL_CNT_1, LVL_CNT_4, LVL_CNT_8};
  logic [33:0] rq [$];
  logic [1:0] bq [$];
  logic [31:0] tx [0:8];
  always #2 core_clk_i = ~core_clk_i;
  sds_spi_core i_sds_spi_core (.core_clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .spi_sclk_o, .spi_mosi_o, .spi_cs_n_o, .spi_miso_i, .irq_o);
  sds_spi_peer #(.FB(FB)) i_sds_spi_peer (.sclk_i(spi_sclk_o), .mosi_i(spi_mosi_o),
    .cs_n_i(spi_cs_n_o), .miso_o(spi_miso_i));
  // ********
  // Tasks
  // ********
  task automatic give_verdict();
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  // Every wait is bounded; running out ends the run as a failure
  task automatic guard(inout int n);
    n++;
    if (n > 2000) begin
      n_errors++;
      give_verdict();
    end
  endtask : guard
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    bit b = 1'b0;
    bq.push_back(r);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    while (!b) begin
      @(posedge core_clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      b = s_axi_bvalid_o;
      if (b) s_axi_bready_i <= 1'b0;
      guard(n);
    end
    @(posedge core_clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n = 0;
    bit d = 1'b0;
    rq.push_back({r, e});
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    while (!d) begin
      @(posedge core_clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      d = s_axi_rvalid_o;
      if (d) s_axi_rready_i <= 1'b0;
      guard(n);
    end
    @(posedge core_clk_i);
  endtask : rd
  task automatic irq_is(input logic e);
    repeat (2) @(posedge core_clk_i);
    chk({33'h0, irq_o}, {33'h0, e});
  endtask : irq_is
  task automatic frames(input int k);
    int n = 0;
    while (i_sds_spi_peer.nf < k) begin
      @(posedge core_clk_i);
      guard(n);
    end
    repeat (3) @(posedge core_clk_i);
  endtask : frames
  // One high and one low phase of sclk make a bit period
  task automatic period();
    int n = 0;
    int t = 0;
    while (!spi_sclk_o) begin
      @(posedge core_clk_i);
      guard(n);
    end
    while (spi_sclk_o) begin
      @(posedge core_clk_i);
      t++;
      guard(n);
    end
    while (!spi_sclk_o) begin
      @(posedge core_clk_i);
      t++;
      guard(n);
    end
    chk(34'(t), 34'(PS * (1 + SERIAL_CLOCK_RATE_SETTING)));
  endtask : period
  // ********
  // Scoreboard and main sequence
  // ********
  // Each bus answer is matched with the oldest note
  always @(posedge core_clk_i) begin
    if (s_axi_rvalid_o && s_axi_rready_i)
      chk({s_axi_rresp_o, s_axi_rdata_o}, rq.pop_front());
    if (s_axi_bvalid_o && s_axi_bready_i)
      chk({32'h0, s_axi_bresp_o}, {32'h0, bq.pop_front()});
  end
  initial begin
    void'($urandom(87));
    for (int i = 0; i < 16; i++) i_sds_spi_peer.rep[i] = 8'($urandom);
    for (int i = 0; i < 9; i++) tx[i] = $urandom;
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    rd(OFS_FIFO_AND_BUSY_FLAGS, 32'h3, RESP_OKAY);
    rd(OFS_INTERRUPT_ENABLE_MASK, 32'h0, RESP_OKAY);
    rd(OFS_BIT_RATE_PRESCALER, 32'h0, RESP_OKAY);
    rd(OFS_FIFO_DATA_PORT, 32'h0, RESP_OKAY);
    rd(8'h24, 32'h0, RESP_SLVERR);
    wr(OFS_FIFO_AND_BUSY_FLAGS, 32'h0, RESP_SLVERR);
    wr(OFS_FRAME_CFG, 32'((SERIAL_CLOCK_RATE_SETTING << SCR_LSB) | (FB - 1)), RESP_OKAY);
    wr(OFS_BIT_RATE_PRESCALER, PS, RESP_OKAY);
    rd(OFS_BIT_RATE_PRESCALER, PS, RESP_OKAY);
    wr(OFS_LINK_CFG, 32'(LVL_SEL_8) << TX_SEL_LSB, RESP_OKAY);
    wr(OFS_INTERRUPT_ENABLE_MASK, 32'h8, RESP_OKAY);
    // Ninth word meets a full transmit fifo and is dropped
    for (int i = 0; i < 9; i++) begin
      wr(OFS_FIFO_DATA_PORT, tx[i], RESP_OKAY);
      if (i == 6) irq_is(1'b0);
      if (i == 7) irq_is(1'b1);
    end
    rd(OFS_FIFO_AND_BUSY_FLAGS, 32'h10, RESP_OKAY);
    wr(OFS_INTERRUPT_ENABLE_MASK, 32'h0, RESP_OKAY);
    irq_is(1'b0);
    wr(OFS_LINK_CFG, (32'(LVL_SEL_8) << TX_SEL_LSB) | 32'h1, RESP_OKAY);
    period();
    rd(OFS_FIFO_AND_BUSY_FLAGS, 32'h12, RESP_OKAY);
    frames(8);
    for (int i = 0; i < 8; i++) chk(34'(i_sds_spi_peer.got[i]), 34'(tx[i][7:0]));
    wr(OFS_FIFO_DATA_PORT, tx[8], RESP_OKAY);
    frames(9);
    rd(OFS_FIFO_AND_BUSY_FLAGS, 32'h0f, RESP_OKAY);
    wr(OFS_INTERRUPT_ENABLE_MASK, 32'h1, RESP_OKAY);
    irq_is(1'b1);
    wr(OFS_EVENT_CLEAR, 32'h1, RESP_OKAY);
    irq_is(1'b0);
    wr(OFS_INTERRUPT_ENABLE_MASK, 32'h2, RESP_OKAY);
    irq_is(1'b1);
    wr(OFS_INTERRUPT_ENABLE_MASK, 32'h10, RESP_OKAY);
    irq_is(1'b0);
    wr(OFS_INTERRUPT_ENABLE_MASK, 32'h4, RESP_OKAY);
    // Drain one entry at a time, trying every level code at each fill
    for (int k = 8; k > 0; k--) begin
      for (int c = 0; c < 3; c++) begin
        wr(OFS_LINK_CFG, (32'(c) << RX_SEL_LSB) | 32'h1, RESP_OKAY);
        irq_is(k >= lv[c]);
      end
      rd(OFS_FIFO_DATA_PORT, {24'h0, i_sds_spi_peer.rep[8 - k]}, RESP_OKAY);
    end
    wr(OFS_INTERRUPT_ENABLE_MASK, 32'h20, RESP_OKAY);
    irq_is(1'b1);
    rd(OFS_INTERRUPT_ENABLE_MASK, 32'h20, RESP_OKAY);
    rd(OFS_FIFO_AND_BUSY_FLAGS, 32'h3, RESP_OKAY);
    give_verdict();
  end
endmodule : tb
